// >>> bench/ifs_chk_sva.sv
// assertions on the ports of the identify and feature block
`timescale 1ns/100ps
`default_nettype none
// ========================================
// checker
module ifs_chk import ifs_pkg::*; (
	input wire logic     clock_i,
	input wire logic     rst_n_i,
	input wire ifs_req_t bus_i,
	input wire logic     soft_reset_i,
	input wire logic     flush_done_i,
	input wire logic     flush_req_o,
	input wire logic     low8_only_o,
	input wire logic     iocs16_en_o,
	input wire logic     wcache_o,
	input wire logic     look_o,
	input wire logic     apm_o,
	input wire logic     epo_o,
	input wire logic     iordy_dis_o,
	input wire logic     done_o,
	input wire logic     abort_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	wire logic cmd_w = bus_i.wr && bus_i.addr == 8'h00;
	sequence flush_end_s;
		flush_req_o && flush_done_i;
	endsequence
	sequence flush_out_s;
		!flush_req_o ##0 done_o;
	endsequence
	iocs_inv_a: assert property (iocs16_en_o == !low8_only_o) else $error("iocs16 mismatch");
	cmd_done_a: assert property (cmd_w && !flush_req_o |=> done_o || flush_req_o) else $error("no done");
	flush_end_a: assert property (flush_end_s |=> flush_out_s) else $error("flush end");
	flush_hold_a: assert property (flush_req_o && !flush_done_i |=> flush_req_o) else $error("flush drop");
	flush_wc_a: assert property ($rose(flush_req_o) |-> !wcache_o) else $error("cache on in flush");
	abort_src_a: assert property ($past(rst_n_i) && $changed(abort_o) |-> $past(cmd_w)) else $error("abort");
	feat_hold_a: assert property ($past(rst_n_i) && !$past(cmd_w) && !$past(soft_reset_i) |->
		$stable({wcache_o, look_o, apm_o, epo_o, low8_only_o, iordy_dis_o})) else $error("feature moved");
	done_src_a: assert property (done_o |-> $past(cmd_w && !flush_req_o) || $past(flush_req_o && flush_done_i))
		else $error("stray done");
endmodule
bind ifs_top ifs_chk i_ifs_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .soft_reset_i(soft_reset_i),
	.flush_done_i(flush_done_i), .flush_req_o(flush_req_o), .low8_only_o(low8_only_o), .iocs16_en_o(iocs16_en_o),
	.wcache_o(wcache_o), .look_o(look_o), .apm_o(apm_o), .epo_o(epo_o), .iordy_dis_o(iordy_dis_o),
	.done_o(done_o), .abort_o(abort_o));
`default_nettype wire

// >>> bench/ifs_flush_mdl.sv
// media side that answers a cache flush after a set latency
`timescale 1ns/100ps
`default_nettype none
// ========================================
// flush responder
module ifs_flush_mdl (
	input  wire logic       clock_i,
	input  wire logic [3:0] lat_i,
	input  wire logic       req_i,
	output logic            done_o
);
	logic [3:0] n_r = 4'h0;
	// lat_i 0 answers promptly, larger values stall the flush
	always_ff @(posedge clock_i) begin
		n_r <= req_i ? n_r + 4'h1 : 4'h0;
		done_o <= req_i && n_r == lat_i && !done_o;
	end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench of the identify and feature block
`timescale 1ns/100ps
`default_nettype none
`include "ifs_consts.svh"
// ========================================
// bench
module tb import ifs_pkg::*;;
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        hw_r    = 1'b0;
	logic        soft_r  = 1'b0;
	logic        fail    = 1'b0;
	logic        rd_p    = 1'b0;
	logic        fdone, freq, low8, iocs, wc, look, apm, epo, iod, done, abrt;
	ifs_req_t    bus     = '0;
	ifs_strap_t  strap   = '0;
	ifs_strap_t  s;
	logic [31:0] rdata, r, t;
	logic [31:0] seed    = 32'h0000_d51e;
	logic [15:0] mode    = 16'h0000;
	logic [15:0] w93     = 16'h4000;
	logic [15:0] w89, w90, w128, ma;
	logic [31:0] exp_q[$];
	logic        ab_q[$];
	logic [7:0]  ra_p    = 8'h00;
	logic [31:0] ev;
	int          num_errors = 0;
	int          cmp_count  = 0;
	// feature, bit, value; bit1 no effect, bit2 abort
	logic [15:0] ft[15] = '{16'h0101, 16'h8100, 16'h0211, 16'haa21, 16'h5520, 16'h0531, 16'h8530, 16'h0941,
		16'h8940, 16'h6651, 16'hcc50, 16'h6902, 16'h9602, 16'h9702, 16'h1006};
	// count, abort, expected mode word
	logic [31:0] xt[9] = '{32'h0100_0040, 32'h0000_0000, 32'h0c00_0200, 32'h2200_2600, 32'h4500_5a00,
		32'h0d01_5a00, 32'h2301_5a00, 32'h8001_5a00, 32'h4601_5a00};
	logic [15:0] el[6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h01fc, 16'h01fd};

	ifs_top i_ifs_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata), .hw_reset_i(hw_r),
		.soft_reset_i(soft_r), .strap_i(strap), .sec_fail_i(fail), .flush_done_i(fdone), .flush_req_o(freq),
		.low8_only_o(low8), .iocs16_en_o(iocs), .wcache_o(wc), .look_o(look), .apm_o(apm), .epo_o(epo),
		.iordy_dis_o(iod), .done_o(done), .abort_o(abrt));
	ifs_flush_mdl i_ifs_flush_mdl (.clock_i(clock_i), .lat_i(4'h6), .req_i(freq), .done_o(fdone));

	always #12.5 clock_i = ~clock_i;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] enc(input logic [15:0] m);
		return m == 16'h0000 ? 16'h0000 : m > `IFS_ER_MAX_MIN ? 16'h00ff : (m + 16'h0001) >> 1;
	endfunction
	function automatic logic [7:0] bs(input logic [15:0] w);
		return w[15:8] + w[7:0];
	endfunction
	task automatic cmp(input logic [31:0] g, e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_b(input logic g, e);
		cmp({31'h0000_0000, g}, {31'h0000_0000, e});
	endtask
	task automatic idle();
		bus <= '0;
		@(posedge clock_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock_i);
	endtask
	// expected read data queued here, checked by the watcher below
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back({16'h0000, e});
		bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge clock_i);
	endtask
	task automatic word(input logic [7:0] i, input logic [15:0] e);
		wr(8'h1c, {24'h00_0000, i});
		rd(8'h20, e);
	endtask
	// expected abort level noted here, checked when done_o shows
	task automatic setf(input logic [7:0] f, c, input logic ab);
		ab_q.push_back(ab);
		wr(8'h04, {24'h00_0000, f});
		wr(8'h08, {24'h00_0000, c});
		wr(8'h00, 32'h0000_00ef);
		idle();
	endtask
	task automatic soft_p();
		soft_r <= 1'b1;
		idle();
		soft_r <= 1'b0;
	endtask
	task automatic fail_p();
		fail <= 1'b1;
		idle();
		fail <= 1'b0;
		idle();
	endtask
	task automatic give_verdict();
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clock_i) begin
		if (rd_p) begin
			ev = exp_q.pop_front();
			cmp(rdata, ev);
			if (ra_p == 8'h10)
				cmp({25'h000_0000, iod, epo, apm, look, wc, low8, ~iocs}, {25'h000_0000, ev[6], ev[4:0], ev[0]});
		end
		if (done) begin
			cmp_b(ab_q.size() != 0, 1'b1);
			if (ab_q.size() != 0)
				cmp_b(abrt, ab_q.pop_front());
		end
		rd_p <= bus.rd;
		ra_p <= bus.addr;
	end

	initial begin
		#50us;
		num_errors++;
		give_verdict();
	end

	initial begin
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'b1;
		rd(8'h10, mode);
		word(8'h5d, w93);
		rd(8'h30, 16'h0000);
		foreach (ft[i]) begin
			setf(ft[i][15:8], 8'h00, ft[i][2]);
			if (!ft[i][1])
				mode[ft[i][7:4]] = ft[i][0];
			rd(8'h10, mode);
		end
		// commands during a flush are dropped, look-ahead must stay off
		setf(8'h82, 8'h00, 1'b0);
		wr(8'h04, 32'h0000_00aa);
		wr(8'h00, 32'h0000_00ef);
		rd(8'h0c, 16'h0001);
		for (int i = 0; i < 20 && freq; i++)
			idle();
		cmp_b(freq, 1'b0);
		rd(8'h10, 16'h0000);
		setf(8'h66, 8'h00, 1'b0);
		setf(8'haa, 8'h00, 1'b0);
		soft_p();
		rd(8'h10, 16'h0024);
		setf(8'hcc, 8'h00, 1'b0);
		soft_p();
		rd(8'h10, 16'h0000);
		foreach (xt[i]) begin
			setf(8'h03, xt[i][31:24], xt[i][16]);
			rd(8'h10, xt[i][15:0]);
		end
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			ma = i < 6 ? el[i] : {6'h00, r[25:16]};
			w89 = enc(ma);
			w90 = enc({6'h00, r[9:0]});
			wr(8'h18, {6'h00, r[9:0], ma});
			word(8'h59, w89);
			word(8'h5a, w90);
		end
		wr(8'h14, 32'h0000_012f);
		word(8'h80, 16'h012f);
		wr(8'h14, 32'h0000_0121);
		w128 = 16'h0021;
		word(8'h80, w128);
		repeat (4) fail_p();
		word(8'h80, w128);
		fail_p();
		word(8'h80, w128 | 16'h0010);
		ab_q.push_back(1'b1);
		wr(8'h00, 32'h0000_00f4);
		idle();
		for (int i = 0; i < 2; i++) begin
			r = rnd();
			s = {r[7], i[0], r[5:0]};
			strap <= s;
			hw_r <= 1'b1;
			repeat (3) idle();
			hw_r <= 1'b0;
			w93 = {2'b01, s.cblid, s.dev1 ? {1'b0, s.pdiag_seen, s.num_method, 1'b1, 8'h00} :
				{6'h00, s.resp_dev1, s.dasp_seen, s.pdiag_seen, s.diag_pass, s.num_method, 1'b1}};
			// strap moves outside hardware reset and must not show
			strap <= ~s;
			repeat (2) idle();
			word(8'h5d, w93);
		end
		ab_q.push_back(1'b0);
		wr(8'h00, 32'h0000_00f4);
		idle();
		word(8'h80, w128);
		word(8'hd9, 16'h0001);
		r = rnd();
		wr(8'h24, {24'h00_0000, r[7:0]});
		t[7:0] = r[7:0] + bs(w89) + bs(w90) + bs(w93) + bs(w128) + 8'ha6;
		word(8'hff, {8'h00 - t[7:0], 8'ha5});
		repeat (3) idle();
		cmp(exp_q.size(), 32'h0000_0000);
		cmp(ab_q.size(), 32'h0000_0000);
		give_verdict();
	end
endmodule
`default_nettype wire

// >>> core/ifs_top.sv
// identify words and set-features decoder of the drive
//
// How it works
// - normal erase time: 0, minutes/2, 255
// - enhanced erase time uses same encoding
// - reset word low bits change only during reset
// - reset word bit15 zero, bit14 one
// - bit13 holds cable id level sensed at hardware reset
// - device 1 fills bits 12..8, else zero
// - device 0 fills bits 7..0, else zero
// - numbering method 01 jumper, 10 csel, 11 other
// - security word support/enable/lock/freeze/enhanced bits
// - expired attempts abort unlock/erase until reset
// - bit8 gives maximum level when enabled
// - rotation word always reads 0001h
// - integrity word carries signature and checksum
// - 01h eight-bit transfers, 81h sixteen-bit
// - 02h/82h write cache, flush on disable
// - 03h selects transfer mode from count
// - decode transfer type and mode number
// - one pio mode always selected
// - 66h/cch gate defaults on soft reset
// - 55h look-ahead off default, aah on
// - apm, extended power, and accepted no-ops
`timescale 1ns/100ps
`default_nettype none
`include "ifs_consts.svh"

module ifs_top import ifs_pkg::*; #(
	parameter logic [3:0] MAX_FAILS  = 4'd5,
	parameter logic [2:0] PIO_MAX    = 3'd4,
	parameter logic [2:0] MDMA_MAX   = 3'd2,
	parameter logic [2:0] UDMA_MAX   = 3'd5,
	parameter logic [7:0] UNLOCK_CMD = 8'hF2,
	parameter logic [7:0] ERASE_CMD  = 8'hF4
) (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire ifs_req_t    bus_i,
	output logic [31:0]      rdata_o,
	input  wire logic        hw_reset_i,
	input  wire logic        soft_reset_i,
	input  wire ifs_strap_t  strap_i,
	input  wire logic        sec_fail_i,
	input  wire logic        flush_done_i,
	output logic             flush_req_o,
	output logic             low8_only_o,
	output logic             iocs16_en_o,
	output logic             wcache_o,
	output logic             look_o,
	output logic             apm_o,
	output logic             epo_o,
	output logic             iordy_dis_o,
	output logic             done_o,
	output logic             abort_o
);

	// ==========================================
	// elaboration checks
	// a zero limit would act as one, expiring security at the first failure
	if (MAX_FAILS == 4'd0) begin : g_bad_fails
		$error("MAX_FAILS must be nonzero");
	end
	// a security code equal to the feature code would shadow set-features
	if (UNLOCK_CMD == `IFS_CMD_SETF || ERASE_CMD == `IFS_CMD_SETF) begin : g_bad_cmd
		$error("security command codes must differ from the set-features code");
	end

	// ==========================================
	// erase time encoding
	// minutes round up to the next two-minute step
	function automatic logic [7:0] enc_erase(
		input logic [15:0] m
	);
		logic [15:0] h;
		h = 16'h0000;
		if (m == 16'h0000) begin
			enc_erase = 8'h00;
		end else if (m > `IFS_ER_MAX_MIN) begin
			enc_erase = `IFS_ER_OVER;
		end else begin
			h = (m + 16'h0001) >> 1;
			enc_erase = h[7:0];
		end
	endfunction

	function automatic logic [7:0] bsum(
		input logic [15:0] w
	);
		bsum = w[15:8] + w[7:0];
	endfunction

	ifs_state_t st_r;
	ifs_state_t st_nxt;

	// ==========================================
	// identify words
	logic [15:0] w_er_norm;
	logic [15:0] w_er_enh;
	logic [15:0] w_rst;
	logic [15:0] w_sec;
	logic [15:0] w_integ;
	logic [7:0]  csum;
	logic [15:0] w_sel;

	assign w_er_norm = {8'h00, enc_erase(st_r.er_norm)};
	assign w_er_enh  = {8'h00, enc_erase(st_r.er_enh)};
	assign w_rst     = {`IFS_RST_TOP, st_r.cbl, st_r.rst_res};

	always_comb begin
		w_sec = 16'h0000;
		w_sec[5:0] = st_r.sec_ctl[5:0];
		// written bit 4 is ignored, the live expire flag shows here
		w_sec[`IFS_SEC_EXP_BIT] = st_r.expired;
		w_sec[`IFS_SEC_LVL_BIT] = st_r.sec_ctl[8] & st_r.sec_ctl[1];
	end

	// the other words of the block are summed by software into sum_base
	assign csum = st_r.sum_base + bsum(w_er_norm) + bsum(w_er_enh)
		+ bsum(w_rst) + bsum(w_sec) + bsum(`IFS_ROT_VAL)
		+ `IFS_SIGNATURE;
	assign w_integ = {8'h00 - csum, `IFS_SIGNATURE};

	always_comb begin
		unique case (st_r.idx)
			`IFS_W_ER_NORM: w_sel = w_er_norm;
			`IFS_W_ER_ENH:  w_sel = w_er_enh;
			`IFS_W_RST:     w_sel = w_rst;
			`IFS_W_SEC:     w_sel = w_sec;
			`IFS_W_ROT:     w_sel = `IFS_ROT_VAL;
			`IFS_W_INTEG:   w_sel = w_integ;
			default:        w_sel = 16'h0000;
		endcase
	end

	// ==========================================
	// reset result capture
	// reserved bits 12 and 7 are never set
	logic [12:0] rst_cap;

	always_comb begin
		rst_cap = 13'h0000;
		if (strap_i.dev1) begin
			rst_cap[8]     = 1'b1;
			rst_cap[11]    = strap_i.pdiag_seen;
			rst_cap[10:9]  = strap_i.num_method;
		end else begin
			rst_cap[0]     = 1'b1;
			rst_cap[6]     = strap_i.resp_dev1;
			rst_cap[5]     = strap_i.dasp_seen;
			rst_cap[4]     = strap_i.pdiag_seen;
			rst_cap[3]     = strap_i.diag_pass;
			rst_cap[2:1]   = strap_i.num_method;
		end
	end

	// ==========================================
	// transfer mode decode
	logic [4:0] xt;
	logic [2:0] xm;
	logic       xok;

	assign xt = st_r.cnt[7:3];
	assign xm = st_r.cnt[2:0];
	// flow-control pio, multiword and ultra limits are parameters, default pio is fixed at 1; out-of-range modes abort rather than clamp

	always_comb begin
		unique case (xt)
			`IFS_XT_PIO_DEF:  xok = (xm <= 3'd1);
			`IFS_XT_PIO_FLOW: xok = (xm <= PIO_MAX);
			`IFS_XT_MDMA:     xok = (xm <= MDMA_MAX);
			`IFS_XT_UDMA:     xok = (xm <= UDMA_MAX);
			default:          xok = 1'b0;
		endcase
	end

	// ==========================================
	// command and register logic
	logic sel_cmd;
	logic setf;
	logic sec_cmd;
	logic       exp_base;
	logic [3:0] fail_base;

	assign sel_cmd = bus_i.wr && (bus_i.addr == `IFS_OFS_CMD);
	assign setf    = sel_cmd && (bus_i.wdata[7:0] == `IFS_CMD_SETF);
	assign sec_cmd = sel_cmd && ((bus_i.wdata[7:0] == UNLOCK_CMD)
		|| (bus_i.wdata[7:0] == ERASE_CMD));

	always_comb begin
		st_nxt = st_r;
		st_nxt.done  = 1'b0;
		st_nxt.rdata = 32'h0000_0000;

		// software reset honours the defaults switch
		if (soft_reset_i && !st_r.por_dis) begin
			st_nxt.xfer8     = 1'b0;
			st_nxt.wcache    = 1'b0;
			st_nxt.look      = 1'b0;
			st_nxt.apm       = 1'b0;
			st_nxt.epo       = 1'b0;
			st_nxt.iordy_dis = 1'b0;
			st_nxt.pio       = 3'd0;
			st_nxt.dma       = IFS_DMA_NONE;
			st_nxt.dma_mode  = 3'd0;
		end

		// hardware reset rearms the attempt counter; a failure in the same
		// cycle still counts, so the set side wins over the clear
		exp_base  = hw_reset_i ? 1'b0 : st_r.expired;
		fail_base = hw_reset_i ? 4'd0 : st_r.fails;
		if (hw_reset_i) begin
			st_nxt.rst_res = rst_cap;
			st_nxt.cbl     = strap_i.cblid;
		end
		st_nxt.expired = exp_base;
		st_nxt.fails   = fail_base;
		if (sec_fail_i && !exp_base) begin
			st_nxt.fails = fail_base + 4'd1;
			if (fail_base + 4'd1 >= MAX_FAILS)
				st_nxt.expired = 1'b1;
		end

		if (bus_i.wr) begin
			unique case (bus_i.addr)
				`IFS_OFS_FEAT:  st_nxt.feat     = bus_i.wdata[7:0];
				`IFS_OFS_CNT:   st_nxt.cnt      = bus_i.wdata[7:0];
				`IFS_OFS_SEC:   st_nxt.sec_ctl  = bus_i.wdata[8:0];
				`IFS_OFS_ERASE: begin
					st_nxt.er_norm = bus_i.wdata[15:0];
					st_nxt.er_enh  = bus_i.wdata[31:16];
				end
				`IFS_OFS_IDX:   st_nxt.idx      = bus_i.wdata[7:0];
				`IFS_OFS_SUM:   st_nxt.sum_base = bus_i.wdata[7:0];
				default: ;
			endcase
		end

		// a new command clears the old abort; commands while flushing are dropped
		if (sel_cmd && st_r.fsm == IFS_IDLE) begin
			st_nxt.abort = 1'b0;
			if (sec_cmd && st_r.expired) begin
				st_nxt.abort = 1'b1;
				st_nxt.done  = 1'b1;
			end else if (setf) begin
				st_nxt.done = 1'b1;
				unique case (st_r.feat)
					`IFS_F_8BIT_ON:  st_nxt.xfer8  = 1'b1;
					`IFS_F_8BIT_OFF: st_nxt.xfer8  = 1'b0;
					`IFS_F_WC_ON:    st_nxt.wcache = 1'b1;
					`IFS_F_WC_OFF: begin
						st_nxt.wcache = 1'b0;
						st_nxt.done   = 1'b0;
						st_nxt.fsm    = IFS_FLUSH;
					end
					`IFS_F_XFER: begin
						if (!xok) begin
							st_nxt.abort = 1'b1;
						end else if (xt == `IFS_XT_PIO_DEF) begin
							st_nxt.pio       = 3'd0;
							st_nxt.iordy_dis = xm[0];
						end else if (xt == `IFS_XT_PIO_FLOW) begin
							st_nxt.pio       = xm;
							st_nxt.iordy_dis = 1'b0;
						end else if (xt == `IFS_XT_MDMA) begin
							st_nxt.dma      = IFS_DMA_MW;
							st_nxt.dma_mode = xm;
						end else begin
							st_nxt.dma      = IFS_DMA_UL;
							st_nxt.dma_mode = xm;
						end
					end
					`IFS_F_APM_ON:   st_nxt.apm     = 1'b1;
					`IFS_F_APM_OFF:  st_nxt.apm     = 1'b0;
					`IFS_F_EPO_ON:   st_nxt.epo     = 1'b1;
					`IFS_F_EPO_OFF:  st_nxt.epo     = 1'b0;
					`IFS_F_LA_OFF:   st_nxt.look    = 1'b0;
					`IFS_F_LA_ON:    st_nxt.look    = 1'b1;
					`IFS_F_POR_OFF:  st_nxt.por_dis = 1'b1;
					`IFS_F_POR_ON:   st_nxt.por_dis = 1'b0;
					`IFS_F_NOP_A,
					`IFS_F_NOP_B,
					`IFS_F_NOP_C:    ;
					default:         st_nxt.abort   = 1'b1;
				endcase
			end else begin
				st_nxt.done = 1'b1;
			end
		end

		// completion only once the cache is safe in flash
		if (st_r.fsm == IFS_FLUSH && flush_done_i) begin
			st_nxt.fsm  = IFS_IDLE;
			st_nxt.done = 1'b1;
		end

		// read data stands one cycle only; no wait states are ever inserted
		if (bus_i.rd) begin
			unique case (bus_i.addr)
				`IFS_OFS_FEAT:  st_nxt.rdata = {24'h00_0000, st_r.feat};
				`IFS_OFS_CNT:   st_nxt.rdata = {24'h00_0000, st_r.cnt};
				`IFS_OFS_STAT:  st_nxt.rdata = {29'h0000_0000, st_r.expired,
					st_r.abort, st_r.fsm == IFS_FLUSH};
				`IFS_OFS_MODE:  st_nxt.rdata = {17'h0_0000, st_r.dma_mode,
					st_r.dma, st_r.pio, st_r.iordy_dis, st_r.por_dis,
					st_r.epo, st_r.apm, st_r.look, st_r.wcache, st_r.xfer8};
				`IFS_OFS_SEC:   st_nxt.rdata = {23'h00_0000, st_r.sec_ctl};
				`IFS_OFS_ERASE: st_nxt.rdata = {st_r.er_enh, st_r.er_norm};
				`IFS_OFS_IDX:   st_nxt.rdata = {24'h00_0000, st_r.idx};
				`IFS_OFS_WORD:  st_nxt.rdata = {16'h0000, w_sel};
				`IFS_OFS_SUM:   st_nxt.rdata = {24'h00_0000, st_r.sum_base};
				default:        st_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================
	// state register
	// synchronous reset clears every field, flush state included
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// outputs
	// every level comes from a flip-flop, iocs16_en_o through an inverter
	assign rdata_o     = st_r.rdata;
	assign flush_req_o = (st_r.fsm == IFS_FLUSH);
	assign low8_only_o = st_r.xfer8;
	assign iocs16_en_o = ~st_r.xfer8;
	assign wcache_o    = st_r.wcache;
	assign look_o      = st_r.look;
	assign apm_o       = st_r.apm;
	assign epo_o       = st_r.epo;
	assign iordy_dis_o = st_r.iordy_dis;
	assign done_o      = st_r.done;
	assign abort_o     = st_r.abort;

endmodule
`default_nettype wire

// >>> pkg/ifs_consts.svh
// offsets, field positions, codes and reset values of the identify and feature block
`ifndef IFS_CONSTS_SVH
`define IFS_CONSTS_SVH
`define IFS_OFS_CMD      8'h00
`define IFS_OFS_FEAT     8'h04
`define IFS_OFS_CNT      8'h08
`define IFS_OFS_STAT     8'h0C
`define IFS_OFS_MODE     8'h10
`define IFS_OFS_SEC      8'h14
`define IFS_OFS_ERASE    8'h18
`define IFS_OFS_IDX      8'h1C
`define IFS_OFS_WORD     8'h20
`define IFS_OFS_SUM      8'h24
`define IFS_CMD_SETF     8'hEF
`define IFS_F_8BIT_ON    8'h01
`define IFS_F_WC_ON      8'h02
`define IFS_F_XFER       8'h03
`define IFS_F_APM_ON     8'h05
`define IFS_F_EPO_ON     8'h09
`define IFS_F_LA_OFF     8'h55
`define IFS_F_POR_OFF    8'h66
`define IFS_F_NOP_A      8'h69
`define IFS_F_8BIT_OFF   8'h81
`define IFS_F_WC_OFF     8'h82
`define IFS_F_APM_OFF    8'h85
`define IFS_F_EPO_OFF    8'h89
`define IFS_F_NOP_B      8'h96
`define IFS_F_NOP_C      8'h97
`define IFS_F_LA_ON      8'hAA
`define IFS_F_POR_ON     8'hCC
`define IFS_XT_PIO_DEF   5'h00
`define IFS_XT_PIO_FLOW  5'h01
`define IFS_XT_MDMA      5'h04
`define IFS_XT_UDMA      5'h08
`define IFS_W_ER_NORM    8'h59
`define IFS_W_ER_ENH     8'h5A
`define IFS_W_RST        8'h5D
`define IFS_W_SEC        8'h80
`define IFS_W_ROT        8'hD9
`define IFS_W_INTEG      8'hFF
`define IFS_ROT_VAL      16'h0001
`define IFS_SIGNATURE    8'hA5
`define IFS_ER_MAX_MIN   16'h01FC
`define IFS_ER_OVER      8'hFF
`define IFS_RST_TOP      2'b01
`define IFS_SEC_EXP_BIT  4
`define IFS_SEC_LVL_BIT  8
`endif

// >>> pkg/ifs_pkg.sv
// types of the identify and feature block
package ifs_pkg;
	typedef enum logic [0:0] {
		IFS_IDLE  = 1'b0,
		IFS_FLUSH = 1'b1
	} ifs_fsm_t;
	typedef enum logic [1:0] {
		IFS_DMA_NONE = 2'b00,
		IFS_DMA_MW   = 2'b01,
		IFS_DMA_UL   = 2'b10
	} ifs_dma_t;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} ifs_req_t;
	typedef struct packed {
		logic       cblid;
		logic       dev1;
		logic       pdiag_seen;
		logic       dasp_seen;
		logic       resp_dev1;
		logic       diag_pass;
		logic [1:0] num_method;
	} ifs_strap_t;
	typedef struct packed {
		ifs_fsm_t    fsm;
		logic [7:0]  feat;
		logic [7:0]  cnt;
		logic        xfer8;
		logic        wcache;
		logic        look;
		logic        apm;
		logic        epo;
		logic        por_dis;
		logic        iordy_dis;
		logic [2:0]  pio;
		ifs_dma_t    dma;
		logic [2:0]  dma_mode;
		logic        abort;
		logic        done;
		logic [8:0]  sec_ctl;
		logic [15:0] er_norm;
		logic [15:0] er_enh;
		logic [7:0]  sum_base;
		logic [7:0]  idx;
		logic        cbl;
		logic [12:0] rst_res;
		logic [3:0]  fails;
		logic        expired;
		logic [31:0] rdata;
	} ifs_state_t;
endpackage
